// ---- splk_pkg.sv ----
// Constants and types for the sector protection and lockdown command block
// Contract
// - Opcode 3D 2A 7F FC then sixteen map bytes
// - Chip select rise starts timed program, busy
// - Pointer wraps after sixteenth data byte
// - Reprogram allowed with protection on or off
// - Map program overwrites working buffer one
// - Opcode 32h, three dummies, map shifts out
// - Map bytes leave in sector order
// - Bits after last byte are undefined
// - Chip select rise ends read, output released
// - Opcode 3D 2A 7F 30 plus address locks
// - Chip select rise starts timed lockdown, busy
// - Locked sector refuses erase and program forever
// - Opcode 35h, three dummies, lock map out
// - Sector zero lock uses bits 7:6, 5:4
// - Other sectors lock as FFh or 00h
// - Erased all-ones map byte means protected
// - Sector zero protect pairs 7:6, 5:4
package splk_pkg;
  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_PREFIX_1 = 8'h3D;
  localparam logic [7:0] OPC_PREFIX_2 = 8'h2A;
  localparam logic [7:0] OPC_PREFIX_3 = 8'h7F;
  localparam logic [7:0] OPC_MAP_PROG = 8'hFC;
  localparam logic [7:0] OPC_LOCK = 8'h30;
  localparam logic [7:0] OPC_MAP_READ = 8'h32;
  localparam logic [7:0] OPC_LOCK_READ = 8'h35;
  // ****************************************************************
  // Map layout
  // ****************************************************************
  localparam int NUM_SECTORS = 16;
  localparam int SECT_ADDR_HI = 19;
  localparam int SECT_ADDR_LO = 16;
  localparam int PAGE_ADDR_HI = 15;
  localparam int PAGE_ADDR_LO = 8;
  localparam logic [7:0] LOW_PART_LAST_PAGE = 8'h07;
  localparam logic [7:0] LOCK_LOW_PART = 8'hC0;
  localparam logic [7:0] LOCK_HIGH_PART = 8'h30;
  localparam logic [7:0] LOCK_WHOLE = 8'hFF;
  localparam logic [7:0] MAP_ERASED = 8'hFF;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int MAX_PROGRAM_TIME_US = 3000;
  localparam int MAX_PROGRAM_CYCLES = MAX_PROGRAM_TIME_US * (CLK_HZ / 1_000_000);
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SPLK_IDLE = 2'b00,
    SPLK_PROG = 2'b01,
    SPLK_LOCK = 2'b10
  } splk_job_t;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] index;
  } splk_byte_t;
  typedef struct packed {
    logic req;
    logic [1:0] op;
    logic [3:0] count;
    logic [23:0] addr;
  } splk_cmd_t;
endpackage

// ---- splk_core.sv ----
// Serial command front end and timed map update for protection and lockdown
module splk_core #(
  parameter int PROG_CYCLES = splk_pkg::MAX_PROGRAM_CYCLES,
  parameter int BUF1_DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic busy,
  output logic [127:0] prot_map,
  output logic [127:0] lock_map,
  input wire logic [23:0] access_addr,
  output logic access_locked
);
  import splk_pkg::*;

  // Refuse sizes that the timer and the buffer copy cannot serve
  if (PROG_CYCLES < 1 || BUF1_DEPTH < NUM_SECTORS) begin : g_bad_param
    $error("splk_core: bad parameter");
  end

  localparam logic [1:0] OP_NONE = 2'd0;
  localparam logic [1:0] OP_PROG = 2'd1;
  localparam logic [1:0] OP_LOCK = 2'd2;
  localparam logic [1:0] OP_READ = 2'd3;

  // ****************************************************************
  // Link domain: shift in on sck rise, framing reset while cs_n high
  // ****************************************************************
  logic [5:0] bitcnt_ff;
  logic [6:0] shin_ff;
  logic [23:0] hdr_ff;
  logic [4:0] nbyte_ff;
  logic [1:0] lop_ff;
  logic lread_map_ff;
  logic [23:0] laddr_ff;
  logic [4:0] wrptr_ff;
  logic [7:0] wbuf_ff [NUM_SECTORS];
  logic [NUM_SECTORS-1:0] wseen_ff;
  logic [3:0] rdbyte_ff;
  logic [2:0] rdbit_ff;
  logic lreading_ff;
  logic [7:0] shout_ff;
  logic [127:0] prot_snap_ff;
  logic [127:0] lock_snap_ff;
  logic [127:0] prot_sync_ff, lock_sync_ff;
  wire logic link_rst_n = reset_n & ~cs_n;
  logic [7:0] in_byte;
  assign in_byte = {shin_ff[6:0], si};

  // Header decoder for the program and lockdown commands; read opcodes are matched apart
  function automatic logic [1:0] dec_op(input logic [31:0] h);
    if (h[31:8] == {OPC_PREFIX_1, OPC_PREFIX_2, OPC_PREFIX_3}) begin
      if (h[7:0] == OPC_MAP_PROG) dec_op = OP_PROG;
      else if (h[7:0] == OPC_LOCK) dec_op = OP_LOCK;
      else dec_op = OP_NONE;
    end else begin
      dec_op = OP_NONE;
    end
  endfunction

  // Byte assembly; bit and byte counts restart with every frame
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bitcnt_ff <= 6'h00;
      shin_ff <= 7'h00;
      hdr_ff <= 24'h0;
      nbyte_ff <= 5'h00;
    end else begin
      shin_ff <= in_byte[6:0];
      bitcnt_ff <= (bitcnt_ff[2:0] == 3'd7) ? 6'h00 : bitcnt_ff + 6'h01;
      if (bitcnt_ff[2:0] == 3'd7) begin
        if (nbyte_ff != 5'h1F) nbyte_ff <= nbyte_ff + 5'h01;
        if (nbyte_ff < 5'd4) hdr_ff <= {hdr_ff[15:0], in_byte};
      end
    end
  end

  // Command fields must outlive cs_n rise for the system side to take
  // them, so lop_ff, wrptr_ff and wseen_ff clear at the first bit of the next frame instead
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      lop_ff <= OP_NONE;
      lread_map_ff <= 1'b0;
      laddr_ff <= 24'h0;
      wrptr_ff <= 5'h00;
      wseen_ff <= '0;
    end else if (bitcnt_ff == 6'h00 && nbyte_ff == 5'h00) begin
      lop_ff <= OP_NONE;
      wrptr_ff <= 5'h00;
      wseen_ff <= '0;
    end else if (bitcnt_ff[2:0] == 3'd7) begin
      if (nbyte_ff < 5'd4) begin
        if (nbyte_ff == 5'd0 && (in_byte == OPC_MAP_READ || in_byte == OPC_LOCK_READ)) begin
          lop_ff <= OP_READ;
          lread_map_ff <= (in_byte == OPC_MAP_READ);
        end
        if (nbyte_ff == 5'd3 && lop_ff != OP_READ) begin
          lop_ff <= dec_op({hdr_ff, in_byte});
        end
      end else if (lop_ff == OP_PROG) begin
        wseen_ff[wrptr_ff[3:0]] <= 1'b1;
        wrptr_ff <= {1'b0, wrptr_ff[3:0] + 4'h1};
      end else if (lop_ff == OP_LOCK && nbyte_ff < 5'd7) begin
        laddr_ff <= {laddr_ff[15:0], in_byte};
      end
    end
  end

  // Map bytes land in the staging array; no reset needed for data
  always_ff @(posedge sck) begin
    if (bitcnt_ff[2:0] == 3'd7 && nbyte_ff >= 5'd4 && lop_ff == OP_PROG) begin
      wbuf_ff[wrptr_ff[3:0]] <= in_byte;
    end
  end

  // Read start flag and snapshot of the maps at the last dummy bit
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lreading_ff <= 1'b0;
      rdbyte_ff <= 4'h0;
      rdbit_ff <= 3'd0;
    end else if (lop_ff == OP_READ && nbyte_ff == 5'd3 && bitcnt_ff[2:0] == 3'd7) begin
      lreading_ff <= 1'b1;
      rdbyte_ff <= 4'h0;
      rdbit_ff <= 3'd0;
    end else if (lreading_ff) begin
      rdbit_ff <= rdbit_ff + 3'd1;
      if (rdbit_ff == 3'd7) rdbyte_ff <= rdbyte_ff + 4'h1; // wraps: undefined anyway
    end
  end
  always_ff @(posedge sck) begin
    if (!lreading_ff) begin
      prot_snap_ff <= prot_sync_ff;
      lock_snap_ff <= lock_sync_ff;
    end
  end

  // Output changes on sck fall, host samples on rise
  logic [7:0] cur_byte;
  assign cur_byte = lread_map_ff ? prot_snap_ff[rdbyte_ff*8 +: 8]
                                 : lock_snap_ff[rdbyte_ff*8 +: 8];
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so <= cur_byte[3'd7 - rdbit_ff];
      so_oe <= lreading_ff;
    end
  end

  // ****************************************************************
  // System domain: synchronise chip select, run timed update
  // ****************************************************************
  logic cs_m_ff, cs_s_ff, cs_d_ff;
  splk_job_t job_ff, nxt_job;
  logic [31:0] tmr_ff, nxt_tmr;
  logic [127:0] prot_ff, nxt_prot;
  logic [127:0] lock_ff, nxt_lock;
  logic [1:0] sop_ff;
  logic [23:0] saddr_ff;
  logic [7:0] buf1_ff [BUF1_DEPTH];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cs_m_ff <= 1'b1;
      cs_s_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end else begin
      cs_m_ff <= cs_n;
      cs_s_ff <= cs_m_ff;
      cs_d_ff <= cs_s_ff;
    end
  end
  wire logic cs_rise = cs_s_ff & ~cs_d_ff;

  // Link fields hold from the last sck edge until the next frame, so
  // they are captured here on the synchronised edge; the job starts one clock later.
  logic cs_rise_d_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cs_rise_d_ff <= 1'b0;
      sop_ff <= 2'd0;
      saddr_ff <= 24'h0;
    end else begin
      cs_rise_d_ff <= cs_rise;
      if (cs_rise) begin
        sop_ff <= lop_ff;
        saddr_ff <= laddr_ff;
      end
    end
  end

  // Next state of the timed update
  always_comb begin
    logic [3:0] sect;
    sect = saddr_ff[SECT_ADDR_HI:SECT_ADDR_LO];
    nxt_job = job_ff;
    nxt_tmr = tmr_ff;
    nxt_prot = prot_ff;
    nxt_lock = lock_ff;
    case (job_ff)
      SPLK_IDLE: begin
        // Accepted regardless of global protection state
        if (cs_rise_d_ff && sop_ff == OP_PROG) begin
          nxt_job = SPLK_PROG;
          nxt_tmr = 32'(PROG_CYCLES - 1);
        end else if (cs_rise_d_ff && sop_ff == OP_LOCK) begin
          nxt_job = SPLK_LOCK;
          nxt_tmr = 32'(PROG_CYCLES - 1);
        end
      end
      SPLK_PROG: begin
        if (tmr_ff == 32'h0) begin
          for (int i = 0; i < NUM_SECTORS; i++) begin
            if (wseen_ff[i]) nxt_prot[i*8 +: 8] = wbuf_ff[i];
          end
          nxt_job = SPLK_IDLE;
        end else begin
          nxt_tmr = tmr_ff - 32'h1;
        end
      end
      SPLK_LOCK: begin
        if (tmr_ff == 32'h0) begin
          if (sect == 4'h0) begin
            if (saddr_ff[PAGE_ADDR_HI:PAGE_ADDR_LO] <= LOW_PART_LAST_PAGE)
              nxt_lock[7:0] = lock_ff[7:0] | LOCK_LOW_PART;
            else
              nxt_lock[7:0] = lock_ff[7:0] | LOCK_HIGH_PART;
          end else begin
            nxt_lock[sect*8 +: 8] = LOCK_WHOLE;
          end
          nxt_job = SPLK_IDLE;
        end else begin
          nxt_tmr = tmr_ff - 32'h1;
        end
      end
      default: nxt_job = SPLK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      job_ff <= SPLK_IDLE;
      tmr_ff <= 32'h0;
      prot_ff <= {NUM_SECTORS{MAP_ERASED}};
      lock_ff <= {NUM_SECTORS{LOCK_RESET}};
    end else begin
      job_ff <= nxt_job;
      tmr_ff <= nxt_tmr;
      prot_ff <= nxt_prot;
      lock_ff <= nxt_lock;
    end
  end

  // Working buffer one is clobbered by each map program
  always_ff @(posedge clk_sys) begin
    if (job_ff == SPLK_PROG && tmr_ff == 32'h0) begin
      for (int i = 0; i < NUM_SECTORS; i++) buf1_ff[i] <= wbuf_ff[i];
    end
  end

  // Registered outputs; maps only change when a timed job ends
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      prot_map <= {NUM_SECTORS{MAP_ERASED}};
      lock_map <= '0;
      prot_sync_ff <= {NUM_SECTORS{MAP_ERASED}};
      lock_sync_ff <= '0;
      access_locked <= 1'b0;
    end else begin
      busy <= (nxt_job != SPLK_IDLE);
      prot_map <= nxt_prot;
      lock_map <= nxt_lock;
      prot_sync_ff <= prot_ff;
      lock_sync_ff <= lock_ff;
      // Erase and program gate for the array
      if (access_addr[SECT_ADDR_HI:SECT_ADDR_LO] == 4'h0) begin
        access_locked <= (access_addr[PAGE_ADDR_HI:PAGE_ADDR_LO] <= LOW_PART_LAST_PAGE)
                         ? lock_ff[7] : lock_ff[5];
      end else begin
        access_locked <= lock_ff[access_addr[SECT_ADDR_HI:SECT_ADDR_LO]*8];
      end
    end
  end
endmodule

// ---- splk_core_checker.sv ----
// Port checks for the protection and lockdown block
module splk_core_checker #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic [127:0] prot_map,
  input wire logic [127:0] lock_map,
  input wire logic [23:0] access_addr,
  input wire logic access_locked
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] busy_cnt_ff, nxt_busy_cnt;
  logic [7:0] hit_byte;
  logic hit;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Length of the running busy stretch
  always_comb nxt_busy_cnt = busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) busy_cnt_ff <= 16'h0000;
    else busy_cnt_ff <= nxt_busy_cnt;
  end
  // Expected verdict; sector 0 splits at page 7
  assign hit_byte = lock_map[8 * access_addr[19:16] +: 8];
  assign hit = (access_addr[19:16] != 4'h0) ? (hit_byte == 8'hFF) : (access_addr[15:8] <= 8'h07)
    ? (hit_byte[7:6] == 2'b11) : (hit_byte[5:4] == 2'b11);
  sequence job_start;
    !busy ##1 busy;
  endsequence
  sequence cs_idle;
    cs_n [*3];
  endsequence
  busy_after_frame_a: assert property (
    job_start |-> $past(cs_n, 3) && !$past(cs_n, 7)) else $error("Busy start");
  busy_length_a: assert property (
    $fell(busy) |-> busy_cnt_ff >= PROG_CYCLES && busy_cnt_ff <= PROG_CYCLES + 2)
    else $error("Busy length");
  prot_update_a: assert property (
    !$stable(prot_map) |-> $fell(busy)) else $error("Map update time");
  lock_update_a: assert property (
    !$stable(lock_map) |-> $fell(busy)) else $error("Lock update time");
  lock_sticky_a: assert property (
    ($past(lock_map) & ~lock_map) == 128'h0) else $error("Lock cleared");
  lock_query_a: assert property (
    access_locked == $past(hit)) else $error("Lock query");
  so_release_a: assert property (
    cs_idle |-> !so_oe) else $error("Output not released");
  so_drive_a: assert property (
    $rose(so_oe) |-> !cs_n) else $error("Output outside frame");
endmodule
bind splk_core splk_core_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .cs_n(cs_n), .so_oe(so_oe), .busy(busy), .prot_map(prot_map),
  .lock_map(lock_map), .access_addr(access_addr), .access_locked(access_locked));

// ---- splk_host_model.sv ----
// Host serial controller model framing commands on the link
module splk_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  int slow = 0;
  // Link clock stands low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Frame of n bytes MSB first; last sixteen bytes back
  task automatic send(input int n, input logic [167:0] d, output logic [127:0] m);
    logic [7:0] q;
    #40 cs_n = 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        si = d[8 * b + i];
        #32 q[i] = so;
        sck = 1'b1;
        #32 sck = 1'b0;
      end
      m = {q, m[127:8]};
      #(slow); // Stall between bytes
    end
    #32 cs_n = 1'b1;
    si = ~si; // Released line must not hold its last bit
  endtask
endmodule

// ---- splk_core_tb.sv ----
// Self-checking bench for the protection and lockdown commands
module splk_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import splk_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] access_addr = 24'h000000;
  logic sck, cs_n, si, so, so_oe, busy, access_locked;
  logic so_line;
  logic [127:0] prot_map, lock_map, exp_p, exp_l, m;
  logic [23:0] la [3] = '{24'h051234, 24'h000300, 24'h000800};
  logic [7:0] lb [3] = '{8'hFF, 8'hC0, 8'hF0};
  int ls [3] = '{5, 0, 0};
  int fail_count = 0;
  int n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  splk_core #(.PROG_CYCLES(20)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .sck(sck),
    .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .busy(busy), .prot_map(prot_map),
    .lock_map(lock_map), .access_addr(access_addr), .access_locked(access_locked));
  // Released output shows the inverse so a stale bit cannot pass
  assign so_line = so_oe ? so : ~so;
  splk_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
  // Compare and count
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded wait on busy; running out ends the run
  task automatic wait_busy(input logic v, input int lim);
    for (int i = 0; i < lim && busy !== v; i++) @(negedge clk_sys);
    if (busy !== v) begin
      fail_count++;
      $display("Error at %0t: busy %h", $time, busy);
      print_verdict();
    end
  endtask
  // Whole job, then the idle gap needed between frames
  task automatic wait_job();
    wait_busy(1'b1, 30);
    wait_busy(1'b0, 60);
    repeat (5) @(negedge clk_sys);
  endtask
  // Header bytes, first sent in the low bits
  function automatic logic [31:0] hdr(input logic [7:0] opc);
    return {opc, OPC_PREFIX_3, OPC_PREFIX_2, OPC_PREFIX_1};
  endfunction
  // Hang guard
  initial begin
    #1ms;
    fail_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(prot_map, {16{MAP_ERASED}});
    chk(lock_map, 128'h0);
    // Valid values; seventeenth byte wraps onto sector 0
    for (int k = 0; k < 16; k++) exp_p[8 * k +: 8] = k[0] ? 8'hFF : 8'h00;
    exp_p[7:0] = 8'h30;
    host.send(21, {8'hC0, exp_p, hdr(OPC_MAP_PROG)}, m);
    wait_job();
    exp_p[7:0] = 8'hC0;
    chk(prot_map, exp_p);
    // Slow host read, then the output is released
    host.slow = 300;
    host.send(20, {160'h0, OPC_MAP_READ}, m);
    host.slow = 0;
    chk(m, exp_p);
    repeat (4) @(negedge clk_sys);
    chk(so_oe, 1'b0);
    // Whole sector, then both parts of sector 0
    exp_l = 128'h0;
    for (int j = 0; j < 3; j++) begin
      access_addr = la[j];
      repeat (2) @(negedge clk_sys);
      chk(access_locked, 1'b0);
      host.send(7, {112'h0, la[j][7:0], la[j][15:8], la[j][23:16], hdr(OPC_LOCK)}, m);
      wait_job();
      exp_l[8 * ls[j] +: 8] = lb[j];
      chk(lock_map, exp_l);
      chk(access_locked, 1'b1);
    end
    host.send(20, {160'h0, OPC_LOCK_READ}, m);
    chk(m, exp_l);
    print_verdict();
  end
endmodule
